// >>> hw/usb_phy_pkg.sv
// constants and carriers for the transceiver control and status logic
package usb_phy_pkg;

  // clock and slow-tick divider
  localparam int unsigned CLK_HZ   = 25_000_000;
  localparam int unsigned SLOW_HZ  = 32_000;
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;

  // register offsets
  localparam logic [7:0] REG_IFC   = 8'h00;
  localparam logic [7:0] REG_GUARD = 8'h01;
  localparam logic [7:0] REG_STAT  = 8'h02;
  localparam logic [7:0] REG_LINE  = 8'h03;
  localparam logic [7:0] REG_CHG   = 8'h04;

  // interface_control fields
  localparam int unsigned IFC_SERIAL = 0;
  localparam int unsigned IFC_UART   = 2;
  localparam int unsigned IFC_AUTO   = 4;
  localparam int unsigned IFC_SPD_LO = 5;
  localparam int unsigned IFC_HOST   = 7;
  localparam logic [7:0]  IFC_RST    = 8'h20;

  // guard and charger fields
  localparam int unsigned GUARD_EN  = 0;
  localparam logic [7:0]  GUARD_RST = 8'h01;
  localparam int unsigned CHG_MODE_LO = 0;
  localparam int unsigned CHG_SW_VAL  = 2;
  localparam int unsigned CHG_STEP    = 3;
  localparam logic [7:0]  CHG_RST     = 8'h00;

  // speeds and link commands
  localparam logic [1:0] SPD_HS = 2'h0;
  localparam logic [1:0] SPD_FS = 2'h1;
  localparam logic [1:0] SPD_LS = 2'h2;
  localparam logic [7:0] TXCMD_NOPID = 8'h40;

  // accessory range codes
  localparam logic [1:0] RANGE_A    = 2'h3;
  localparam logic [1:0] RANGE_B    = 2'h2;
  localparam logic [1:0] RANGE_C    = 2'h1;
  localparam logic [1:0] RANGE_NONE = 2'h0;

  // hs bit coding
  localparam logic [2:0] STUFF_RUN = 3'h6;
  localparam logic [2:0] LAST_BIT  = 3'h7;

  // charger debounce in slow ticks, or in step writes when software-stepped
  localparam logic [3:0] CHG_DEBOUNCE = 4'h8;

  typedef enum logic [1:0] {CHG_HW, CHG_SW, CHG_SWFSM} chg_mode_e;

  // decoded status byte
  typedef struct packed {
    logic       vbus_valid;
    logic       session_ok;
    logic       b_session_ok;
    logic       session_over;
    logic       id_open_flag;
    logic       id_tied_low;
    logic [1:0] accessory_id_range;
  } status_s;

endpackage

// >>> hw/usb_phy_status_resume_ctrl.sv
// transceiver control: status decode, fs/ls and hs paths, autoresume, uart, charger
//
// Chosen here: strobed register access and the address map.
module usb_phy_status_resume_ctrl #(
  parameter int unsigned WAKE_GUARD_TIMEOUT = 32  // in slow ticks
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  // raw comparators: vbus valid, session, b-session, session-end
  input  wire logic [3:0] vbus_cmp,
  // raw id comparators: above gnd-to-c, c-to-b, b-to-a, a-to-float
  input  wire logic [3:0] id_cmp,
  // fs/ls receivers and driver
  input  wire logic       dp_se_rx,
  input  wire logic       dm_se_rx,
  input  wire logic       diff_rx_out,
  output logic            fs_oe,
  output logic            fs_dp_out,
  output logic            fs_dm_out,
  output logic [1:0]      line_speed,
  // link fs/ls transmit request and serial/uart pins
  input  wire logic       fs_tx_en,
  input  wire logic       fs_tx_dp,
  input  wire logic       fs_tx_dm,
  input  wire logic       uart_tx,
  output logic            serial_rx,
  // link transmit command
  input  wire logic       txcmd_valid,
  input  wire logic [7:0] txcmd,
  // hs line side
  input  wire logic       hs_bit_en,
  input  wire logic       hs_squelch,
  input  wire logic       hs_rx_bit,
  output logic            hs_tx_bit,
  output logic            hs_tx_active,
  // hs link side
  output logic [7:0]      hs_rx_byte,
  output logic            hs_rx_valid,
  input  wire logic [7:0] hs_tx_byte,
  input  wire logic       hs_tx_valid,
  output logic            hs_tx_ready,
  // charger detection
  input  wire logic       chg_dm_cmp,
  output logic            chg_dp_src,
  output logic            charger_found_out
);

  // ---- register file ----
  logic [7:0] interface_control, next_interface_control;
  logic [7:0] guard_ctrl, next_guard_ctrl;
  logic [7:0] chg_ctrl, next_chg_ctrl;
  logic [7:0] next_rdata;
  logic       chg_step, next_chg_step;
  usb_phy_pkg::status_s status;
  logic [7:0] line_state;

  logic wake_guard_enable;
  logic serial_port_select;
  assign wake_guard_enable  = guard_ctrl[usb_phy_pkg::GUARD_EN];
  assign serial_port_select = interface_control[usb_phy_pkg::IFC_UART];

  // writes and one-cycle-late read data; unmapped reads give zero
  always_comb begin
    next_interface_control = interface_control;
    next_guard_ctrl        = guard_ctrl;
    next_chg_ctrl          = chg_ctrl;
    next_chg_step          = 1'b0;
    next_rdata             = 8'h00;
    if (wr) begin
      case (addr)
        usb_phy_pkg::REG_IFC:   next_interface_control = wdata;
        usb_phy_pkg::REG_GUARD: next_guard_ctrl = {7'h00, wdata[usb_phy_pkg::GUARD_EN]};
        usb_phy_pkg::REG_CHG: begin
          next_chg_ctrl = {5'h00, wdata[2:0]};
          next_chg_step = wdata[usb_phy_pkg::CHG_STEP];
        end
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        usb_phy_pkg::REG_IFC:   next_rdata = interface_control;
        usb_phy_pkg::REG_GUARD: next_rdata = guard_ctrl;
        usb_phy_pkg::REG_STAT:  next_rdata = status;
        usb_phy_pkg::REG_LINE:  next_rdata = line_state;
        usb_phy_pkg::REG_CHG:   next_rdata = chg_ctrl;
        default:                next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      interface_control <= usb_phy_pkg::IFC_RST;
      guard_ctrl        <= usb_phy_pkg::GUARD_RST;
      chg_ctrl          <= usb_phy_pkg::CHG_RST;
      chg_step          <= 1'b0;
      rdata             <= 8'h00;
    end else begin
      interface_control <= next_interface_control;
      guard_ctrl        <= next_guard_ctrl;
      chg_ctrl          <= next_chg_ctrl;
      chg_step          <= next_chg_step;
      rdata             <= next_rdata;
    end
  end

  // ---- comparator synchronisers; first stage feeds only the second ----
  logic [7:0] cmp_meta, cmp_sync;
  always_ff @(posedge clk) begin
    if (srst) begin
      cmp_meta <= 8'h00;
      cmp_sync <= 8'h00;
    end else begin
      cmp_meta <= {id_cmp, vbus_cmp};
      cmp_sync <= cmp_meta;
    end
  end

  // status decode from synchronised comparators
  usb_phy_pkg::status_s next_status;
  always_comb begin
    next_status.vbus_valid   = cmp_sync[0];
    next_status.session_ok   = cmp_sync[1];
    next_status.b_session_ok = cmp_sync[2];
    next_status.session_over = ~cmp_sync[3];
    next_status.id_open_flag = cmp_sync[7];
    next_status.id_tied_low  = cmp_sync[4];
    if (cmp_sync[7] || !cmp_sync[4])
      next_status.accessory_id_range = usb_phy_pkg::RANGE_NONE;
    else if (cmp_sync[6])
      next_status.accessory_id_range = usb_phy_pkg::RANGE_A;
    else if (cmp_sync[5])
      next_status.accessory_id_range = usb_phy_pkg::RANGE_B;
    else
      next_status.accessory_id_range = usb_phy_pkg::RANGE_C;
  end

  always_ff @(posedge clk) begin
    if (srst) status <= '0;
    else      status <= next_status;
  end

  // ---- slow tick divider standing in for the 32 kHz oscillator ----
  logic [9:0] slow_cnt, next_slow_cnt;
  logic       slow_tick, next_slow_tick;
  always_comb begin
    next_slow_tick = 1'b0;
    next_slow_cnt  = slow_cnt + 10'h001;
    if (slow_cnt == 10'(usb_phy_pkg::SLOW_DIV - 1)) begin
      next_slow_cnt  = 10'h000;
      next_slow_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      slow_cnt  <= 10'h000;
      slow_tick <= 1'b0;
    end else begin
      slow_cnt  <= next_slow_cnt;
      slow_tick <= next_slow_tick;
    end
  end

  // ---- autoresume with watchdog ----
  logic        resume_drive, next_resume_drive;
  logic [15:0] guard_cnt, next_guard_cnt;
  logic        line_k, line_k_q;
  logic        nopid;
  assign line_k = ~dp_se_rx & dm_se_rx;
  assign nopid  = txcmd_valid && (txcmd == usb_phy_pkg::TXCMD_NOPID);

  // resume starts the cycle after a fresh K, far inside the 1 ms budget
  always_comb begin
    next_resume_drive = resume_drive;
    next_guard_cnt    = guard_cnt;
    if (!resume_drive) begin
      if (interface_control[usb_phy_pkg::IFC_AUTO] && line_k && !line_k_q) begin
        next_resume_drive = 1'b1;
        next_guard_cnt    = 16'h0000;
      end
    end else if (nopid) begin
      next_resume_drive = 1'b0;
    end else if (wake_guard_enable) begin
      if (guard_cnt >= 16'(WAKE_GUARD_TIMEOUT))
        next_resume_drive = 1'b0;
      else if (slow_tick)
        next_guard_cnt = guard_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      resume_drive <= 1'b0;
      guard_cnt    <= 16'h0000;
      line_k_q     <= 1'b0;
    end else begin
      resume_drive <= next_resume_drive;
      guard_cnt    <= next_guard_cnt;
      line_k_q     <= line_k;
    end
  end

  // ---- fs/ls driver, speed select, uart and serial receive ----
  logic [1:0] req_speed, next_line_speed;
  logic       next_fs_oe, next_fs_dp, next_fs_dm, next_serial_rx;
  assign req_speed = interface_control[usb_phy_pkg::IFC_SPD_LO +: 2];

  // resume-K wins over link traffic; idle leaves the line released
  always_comb begin
    next_line_speed = req_speed;
    if (req_speed == usb_phy_pkg::SPD_LS && !interface_control[usb_phy_pkg::IFC_HOST])
      next_line_speed = usb_phy_pkg::SPD_FS;
    else if (req_speed > usb_phy_pkg::SPD_LS)
      next_line_speed = usb_phy_pkg::SPD_FS;
    next_fs_oe = 1'b0;
    next_fs_dp = 1'b0;
    next_fs_dm = 1'b0;
    next_serial_rx = 1'b0;
    if (serial_port_select) begin
      next_fs_oe     = 1'b1;
      next_fs_dm     = uart_tx;
      next_serial_rx = dp_se_rx;
    end else begin
      if (resume_drive) begin
        next_fs_oe = 1'b1;
        next_fs_dm = 1'b1;
      end else if (fs_tx_en && next_line_speed != usb_phy_pkg::SPD_HS) begin
        next_fs_oe = 1'b1;
        next_fs_dp = fs_tx_dp;
        next_fs_dm = fs_tx_dm;
      end
      if (interface_control[usb_phy_pkg::IFC_SERIAL])
        next_serial_rx = diff_rx_out;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      line_speed <= usb_phy_pkg::SPD_FS;
      fs_oe      <= 1'b0;
      fs_dp_out  <= 1'b0;
      fs_dm_out  <= 1'b0;
      serial_rx  <= 1'b0;
    end else begin
      line_speed <= next_line_speed;
      fs_oe      <= next_fs_oe;
      fs_dp_out  <= next_fs_dp;
      fs_dm_out  <= next_fs_dm;
      serial_rx  <= next_serial_rx;
    end
  end

  // ---- hs receive: nrzi decode, unstuff, deserialize lsb first ----
  logic [7:0] rx_sh, next_rx_sh, next_hs_rx_byte;
  logic [2:0] rx_cnt, next_rx_cnt, rx_ones, next_rx_ones;
  logic       rx_prev, next_rx_prev, next_hs_rx_valid, rx_d;
  assign rx_d = ~(hs_rx_bit ^ rx_prev);

  always_comb begin
    next_rx_sh       = rx_sh;
    next_rx_cnt      = rx_cnt;
    next_rx_ones     = rx_ones;
    next_rx_prev     = rx_prev;
    next_hs_rx_byte  = hs_rx_byte;
    next_hs_rx_valid = 1'b0;
    if (hs_squelch || line_speed != usb_phy_pkg::SPD_HS) begin
      next_rx_cnt  = 3'h0;
      next_rx_ones = 3'h0;
      next_rx_prev = 1'b1;
    end else if (hs_bit_en) begin
      next_rx_prev = hs_rx_bit;
      if (rx_ones == usb_phy_pkg::STUFF_RUN) begin
        next_rx_ones = 3'h0;
      end else begin
        next_rx_sh   = {rx_d, rx_sh[7:1]};
        next_rx_ones = rx_d ? rx_ones + 3'h1 : 3'h0;
        next_rx_cnt  = rx_cnt + 3'h1;
        if (rx_cnt == usb_phy_pkg::LAST_BIT) begin
          next_hs_rx_byte  = {rx_d, rx_sh[7:1]};
          next_hs_rx_valid = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_sh       <= 8'h00;
      rx_cnt      <= 3'h0;
      rx_ones     <= 3'h0;
      rx_prev     <= 1'b1;
      hs_rx_byte  <= 8'h00;
      hs_rx_valid <= 1'b0;
    end else begin
      rx_sh       <= next_rx_sh;
      rx_cnt      <= next_rx_cnt;
      rx_ones     <= next_rx_ones;
      rx_prev     <= next_rx_prev;
      hs_rx_byte  <= next_hs_rx_byte;
      hs_rx_valid <= next_hs_rx_valid;
    end
  end

  // ---- hs transmit: one byte held at a time, stuff then nrzi ----
  logic [7:0] tx_sh, next_tx_sh;
  logic [2:0] tx_cnt, next_tx_cnt, tx_ones, next_tx_ones;
  logic       next_tx_active, next_tx_bit, next_tx_ready;

  always_comb begin
    next_tx_sh     = tx_sh;
    next_tx_cnt    = tx_cnt;
    next_tx_ones   = tx_ones;
    next_tx_active = hs_tx_active;
    next_tx_bit    = hs_tx_bit;
    if (!hs_tx_active) begin
      if (hs_tx_valid && hs_tx_ready) begin
        next_tx_sh     = hs_tx_byte;
        next_tx_cnt    = 3'h0;
        next_tx_active = 1'b1;
      end
    end else if (hs_bit_en) begin
      if (tx_ones == usb_phy_pkg::STUFF_RUN) begin
        next_tx_ones = 3'h0;
        next_tx_bit  = ~hs_tx_bit;
      end else begin
        next_tx_bit  = tx_sh[0] ? hs_tx_bit : ~hs_tx_bit;
        next_tx_ones = tx_sh[0] ? tx_ones + 3'h1 : 3'h0;
        next_tx_sh   = {1'b0, tx_sh[7:1]};
        next_tx_cnt  = tx_cnt + 3'h1;
        if (tx_cnt == usb_phy_pkg::LAST_BIT)
          next_tx_active = 1'b0;
      end
    end
    // stuffing run carries across bytes; it clears once the line goes idle
    if (!hs_tx_active && !next_tx_active)
      next_tx_ones = 3'h0;
    next_tx_ready = !next_tx_active && line_speed == usb_phy_pkg::SPD_HS;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_sh        <= 8'h00;
      tx_cnt       <= 3'h0;
      tx_ones      <= 3'h0;
      hs_tx_active <= 1'b0;
      hs_tx_bit    <= 1'b1;
      hs_tx_ready  <= 1'b0;
    end else begin
      tx_sh        <= next_tx_sh;
      tx_cnt       <= next_tx_cnt;
      tx_ones      <= next_tx_ones;
      hs_tx_active <= next_tx_active;
      hs_tx_bit    <= next_tx_bit;
      hs_tx_ready  <= next_tx_ready;
    end
  end

  // ---- charger detection on the slow tick, or on step writes when software-stepped ----
  typedef enum logic [1:0] {CD_IDLE, CD_PROBE, CD_FOUND, CD_NONE} chg_state_e;
  chg_state_e cd_state, next_cd_state;
  logic [3:0] cd_cnt, next_cd_cnt;
  logic       next_chg_dp_src, next_found, cd_adv;
  usb_phy_pkg::chg_mode_e chg_mode;
  assign chg_mode = usb_phy_pkg::chg_mode_e'(chg_ctrl[usb_phy_pkg::CHG_MODE_LO +: 2]);

  // software-stepped mode advances only on a step write, not on the slow tick; a lost session still returns it to idle
  always_comb begin
    cd_adv        = (chg_mode == usb_phy_pkg::CHG_SWFSM) ? chg_step : slow_tick;
    next_cd_state = cd_state;
    next_cd_cnt   = cd_cnt;
    if (!status.session_ok) begin
      next_cd_state = CD_IDLE;
      next_cd_cnt   = 4'h0;
    end else if (cd_adv) begin
      case (cd_state)
        CD_IDLE: next_cd_state = CD_PROBE;
        CD_PROBE: begin
          next_cd_cnt = cd_cnt + 4'h1;
          if (!chg_dm_cmp)
            next_cd_state = CD_NONE;
          else if (cd_cnt == usb_phy_pkg::CHG_DEBOUNCE)
            next_cd_state = CD_FOUND;
        end
        default: ;
      endcase
    end
    next_chg_dp_src = (next_cd_state == CD_PROBE);
    case (chg_mode)
      usb_phy_pkg::CHG_SW: begin
        next_found      = chg_ctrl[usb_phy_pkg::CHG_SW_VAL];
        next_chg_dp_src = 1'b0;
      end
      default: next_found = (next_cd_state == CD_FOUND);
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cd_state          <= CD_IDLE;
      cd_cnt            <= 4'h0;
      chg_dp_src        <= 1'b0;
      charger_found_out <= 1'b0;
    end else begin
      cd_state          <= next_cd_state;
      cd_cnt            <= next_cd_cnt;
      chg_dp_src        <= next_chg_dp_src;
      charger_found_out <= next_found;
    end
  end

  assign line_state = {2'h0, line_speed, charger_found_out, dm_se_rx, dp_se_rx, resume_drive};

  // ---- assertions ----
  // status still shows its reset value on the first edge after release
  property p_vbus_bits;
    @(posedge clk) disable iff (srst)
      !$past(srst) |->
      (status.vbus_valid == $past(cmp_meta[0], 2) && status.session_over != $past(cmp_meta[3], 2));
  endproperty
  a_vbus_bits: assert property (p_vbus_bits) else $error("vbus status off");

  property p_range_clear;
    @(posedge clk) disable iff (srst)
      (status.id_open_flag || !status.id_tied_low) |-> status.accessory_id_range == 2'h0;
  endproperty
  a_range_clear: assert property (p_range_clear) else $error("range not clear");

  property p_resume_start;
    @(posedge clk) disable iff (srst)
      (!resume_drive && interface_control[4] && line_k && !line_k_q && !serial_port_select)
      |=> resume_drive ##1 (fs_oe && fs_dm_out && !fs_dp_out);
  endproperty
  a_resume_start: assert property (p_resume_start) else $error("resume-K late");

  property p_nopid_stop;
    @(posedge clk) disable iff (srst)
      (resume_drive && nopid) |=> !resume_drive;
  endproperty
  a_nopid_stop: assert property (p_nopid_stop) else $error("resume not ended");

  property p_guard_stop;
    @(posedge clk) disable iff (srst)
      (resume_drive && wake_guard_enable && guard_cnt >= 16'(WAKE_GUARD_TIMEOUT)) |=> !resume_drive;
  endproperty
  a_guard_stop: assert property (p_guard_stop) else $error("watchdog ignored");

  property p_auto_off;
    @(posedge clk) disable iff (srst)
      $rose(resume_drive) |-> $past(interface_control[4]);
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("resume without enable");

  property p_uart_path;
    @(posedge clk) disable iff (srst)
      serial_port_select |=> (fs_oe && fs_dm_out == $past(uart_tx) && serial_rx == $past(dp_se_rx));
  endproperty
  a_uart_path: assert property (p_uart_path) else $error("uart path wrong");

  property p_no_ls_device;
    @(posedge clk) disable iff (srst)
      !$past(interface_control[7]) |-> line_speed != 2'h2;
  endproperty
  a_no_ls_device: assert property (p_no_ls_device) else $error("ls as peripheral");

  property p_release;
    @(posedge clk) disable iff (srst)
      (!serial_port_select && !resume_drive && !fs_tx_en) |=> !fs_oe;
  endproperty
  a_release: assert property (p_release) else $error("line not released");

  property p_tx_stuff;
    @(posedge clk) disable iff (srst)
      (hs_tx_active && hs_bit_en && tx_ones == 3'h6) |=> hs_tx_bit != $past(hs_tx_bit);
  endproperty
  a_tx_stuff: assert property (p_tx_stuff) else $error("stuff bit missing");

endmodule // usb_phy_status_resume_ctrl

// >>> sim/link_model.sv
// link-side model: issues the transmit command that ends resume signalling
module link_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // request from the bench
  input  wire logic       send_nopid,
  // command toward the device
  output logic            txcmd_valid,
  output logic [7:0]      txcmd
);
  timeunit 1ns;
  timeprecision 1ps;

  // one-cycle command pulse; idle bus shows the inverse so stale data never matches
  always_ff @(posedge clk) begin
    txcmd_valid <= !srst && send_nopid;
    txcmd       <= (!srst && send_nopid) ? usb_phy_pkg::TXCMD_NOPID : ~usb_phy_pkg::TXCMD_NOPID;
  end
endmodule // link_model

// >>> sim/usb_phy_status_resume_ctrl_tb.sv
// self-checking bench for the transceiver control and status logic
module usb_phy_status_resume_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 2;  // short watchdog limit, in slow ticks
  logic clk, srst, wr, rd, dp_se_rx, dm_se_rx, diff_rx_out, uart_tx, send_nopid;
  logic fs_tx_en, fs_tx_dp, fs_tx_dm, chg_dm_cmp, fs_oe, fs_dp_out, fs_dm_out, serial_rx;
  logic txcmd_valid, hs_tx_bit, hs_tx_active, hs_rx_valid, hs_tx_ready, chg_dp_src;
  logic charger_found_out, hs_bit_en, hs_squelch, hs_rx_bit, hs_tx_valid;
  logic [7:0] addr, wdata, rdata, txcmd, hs_rx_byte, hs_tx_byte;
  logic [3:0] vbus_cmp, id_cmp;
  logic [1:0] line_speed;
  int err_total, num_checks;

  // hs inputs stay idle with squelch high outside the hs test
  usb_phy_status_resume_ctrl #(.WAKE_GUARD_TIMEOUT(TMO)) dut (
    .clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .vbus_cmp, .id_cmp, .dp_se_rx, .dm_se_rx,
    .diff_rx_out, .fs_oe, .fs_dp_out, .fs_dm_out, .line_speed, .fs_tx_en, .fs_tx_dp,
    .fs_tx_dm, .uart_tx, .serial_rx, .txcmd_valid, .txcmd, .hs_bit_en,
    .hs_squelch, .hs_rx_bit, .hs_tx_bit, .hs_tx_active, .hs_rx_byte,
    .hs_rx_valid, .hs_tx_byte, .hs_tx_valid, .hs_tx_ready, .chg_dm_cmp,
    .chg_dp_src, .charger_found_out);

  link_model u_link (.clk, .srst, .send_nopid, .txcmd_valid, .txcmd);

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // waits end on a falling edge so outputs are settled
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(string nm, logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(nm, exp, rdata);
  endtask

  task automatic line(logic dp, logic dm);
    @(posedge clk);
    dp_se_rx <= dp;
    dm_se_rx <= dm;
  endtask

  task automatic t_reset();
    rd_chk("ifc_rst", usb_phy_pkg::REG_IFC, 8'h20);
    rd_chk("guard_rst", usb_phy_pkg::REG_GUARD, 8'h01);
    wr_reg(8'h7f, 8'hff);
    rd_chk("unmapped", 8'h7f, 8'h00);
    line(1'b0, 1'b1);
    cyc(5);
    chk("no_auto", 8'h0, 8'(fs_oe));
    line(1'b1, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_status();
    logic [3:0] ids [5] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'h0};
    logic [1:0] rng [5] = '{2'h0, 2'h3, 2'h2, 2'h1, 2'h0};
    logic [3:0] v;
    for (int i = 0; i < 5; i++) begin
      v = 4'(i * 5);
      @(posedge clk);
      vbus_cmp <= v;
      id_cmp   <= ids[i];
      cyc(5);
      rd_chk("status", usb_phy_pkg::REG_STAT,
             {v[0], v[1], v[2], ~v[3], ids[i][3], ids[i][0], rng[i]});
    end
    $display("test status done");
  endtask

  task automatic t_speed();
    wr_reg(usb_phy_pkg::REG_IFC, 8'h40);
    cyc(2);
    chk("ls_dev", 8'(usb_phy_pkg::SPD_FS), 8'(line_speed));
    wr_reg(usb_phy_pkg::REG_IFC, 8'hc0);
    cyc(2);
    chk("ls_host", 8'(usb_phy_pkg::SPD_LS), 8'(line_speed));
    wr_reg(usb_phy_pkg::REG_IFC, 8'h20);
    @(posedge clk);
    fs_tx_en <= 1'b1;
    fs_tx_dp <= 1'b1;
    cyc(3);
    chk("fs_drive", 8'h3, {6'h0, fs_oe, fs_dp_out});
    @(posedge clk);
    fs_tx_en <= 1'b0;
    cyc(3);
    chk("fs_release", 8'h0, 8'(fs_oe));
    $display("test speed done");
  endtask

  // far end sends K; the device must answer and stop by guard or command
  task automatic t_resume(logic guard);
    int n;
    wr_reg(usb_phy_pkg::REG_GUARD, {7'h0, guard});
    wr_reg(usb_phy_pkg::REG_IFC, 8'h30);
    line(1'b0, 1'b1);
    cyc(4);
    chk("res_k", 8'h5, {5'h0, fs_oe, fs_dp_out, fs_dm_out});
    cyc(600);
    chk("res_hold", 8'h1, 8'(fs_oe));
    if (guard) begin
      for (n = 0; n < 3000 && fs_oe === 1'b1; n++) @(negedge clk);
      chk("wd_stop", 8'h0, 8'(fs_oe));
    end else begin
      cyc(2400);
      chk("no_wd", 8'h1, 8'(fs_oe));
      @(posedge clk);
      send_nopid <= 1'b1;
      @(posedge clk);
      send_nopid <= 1'b0;
      cyc(4);
      chk("nopid_stop", 8'h0, 8'(fs_oe));
    end
    line(1'b1, 1'b0);
    wr_reg(usb_phy_pkg::REG_IFC, 8'h20);
    $display("test resume done");
  endtask

  task automatic t_serial();
    wr_reg(usb_phy_pkg::REG_IFC, 8'h24);
    for (int b = 0; b < 2; b++) begin
      @(posedge clk);
      uart_tx  <= b[0];
      dp_se_rx <= ~b[0];
      cyc(3);
      chk("u_tx", 8'(b[0]), 8'(fs_dm_out));
      chk("u_rx", {7'h0, ~b[0]}, 8'(serial_rx));
    end
    wr_reg(usb_phy_pkg::REG_IFC, 8'h21);
    @(posedge clk);
    diff_rx_out <= 1'b1;
    cyc(3);
    chk("ser_rx", 8'h1, 8'(serial_rx));
    @(posedge clk);
    diff_rx_out <= 1'b0;
    cyc(3);
    chk("ser_rx0", 8'h0, 8'(serial_rx));
    wr_reg(usb_phy_pkg::REG_CHG, 8'h05);
    cyc(3);
    chk("chg_sw", 8'h1, 8'(charger_found_out));
    $display("test serial done");
  endtask

  // one byte out and the same line levels back in; six ones force a stuffed zero
  task automatic t_hs();
    logic       l    = 1'b1;
    logic [8:0] bits = 9'h03f;  // lsb first: six ones, stuffed zero, data bits 6 and 7
    wr_reg(usb_phy_pkg::REG_IFC, 8'h00);
    cyc(3);
    chk("hs_ready", 8'h1, 8'(hs_tx_ready));
    @(posedge clk);
    hs_tx_byte  <= 8'h3f;
    hs_tx_valid <= 1'b1;
    hs_squelch  <= 1'b0;
    @(posedge clk);
    hs_tx_valid <= 1'b0;
    @(negedge clk);
    chk("hs_take", 8'h2, {6'h0, hs_tx_active, hs_tx_ready});
    for (int i = 0; i < 9; i++) begin
      l = bits[i] ? l : ~l;  // nrzi: a zero toggles the line
      @(posedge clk);
      hs_bit_en <= 1'b1;
      hs_rx_bit <= l;
      @(posedge clk);
      hs_bit_en <= 1'b0;
      @(negedge clk);
      chk("hs_tx_line", {7'h0, l}, {7'h0, hs_tx_bit});
    end
    chk("hs_rx_valid", 8'h1, 8'(hs_rx_valid));
    chk("hs_rx_byte", 8'h3f, hs_rx_byte);
    chk("hs_tx_end", 8'h1, {6'h0, hs_tx_active, hs_tx_ready});
    @(posedge clk);
    hs_squelch <= 1'b1;
    wr_reg(usb_phy_pkg::REG_IFC, 8'h20);
    $display("test hs done");
  endtask

  // software-stepped detection: one step to probe, then nine more steps to found
  task automatic t_charger();
    wr_reg(usb_phy_pkg::REG_CHG, 8'h02);
    @(posedge clk);
    vbus_cmp   <= 4'h2;
    chg_dm_cmp <= 1'b1;
    cyc(5);
    for (int s = 0; s < 9; s++) begin
      wr_reg(usb_phy_pkg::REG_CHG, 8'h0a);
    end
    cyc(2);
    chk("chg_probe", 8'h2, {6'h0, chg_dp_src, charger_found_out});
    wr_reg(usb_phy_pkg::REG_CHG, 8'h0a);
    cyc(2);
    chk("chg_found", 8'h1, {6'h0, chg_dp_src, charger_found_out});
    $display("test charger done");
  endtask

  // all inputs set at time zero, then reset for 20 cycles
  initial begin
    {srst, wr, rd, dp_se_rx, uart_tx, diff_rx_out} = 6'h20;
    {hs_bit_en, hs_squelch, hs_rx_bit, hs_tx_valid, hs_tx_byte} = 12'h400;
    {dm_se_rx, send_nopid, fs_tx_en, fs_tx_dp, fs_tx_dm, chg_dm_cmp} = 6'h00;
    {addr, wdata, vbus_cmp, id_cmp} = 24'h0;
    err_total = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_status();
    t_speed();
    t_resume(1'b1);
    t_resume(1'b0);
    t_hs();
    t_serial();
    t_charger();
    end_of_test();
  end

  // hang guard, well beyond the expected run
  initial begin
    #(40 * 20000);
    err_total++;
    end_of_test();
  end
endmodule // usb_phy_status_resume_ctrl_tb
